/* verilog/fpss_cfg.svh */
// offsets, fields, reset values and timing counts for fan source select
`ifndef FPSS_CFG_SVH
`define FPSS_CFG_SVH
`define FPSS_ADDR_W 8
`define FPSS_OFS_INTERVAL 8'hC7
`define FPSS_OFS_BINDING 8'hC8
`define FPSS_OFS_OVERRIDE 8'hC9
`define FPSS_RST_INTERVAL 8'h11
`define FPSS_RST_BINDING 8'h0F
`define FPSS_RST_OVERRIDE 8'h00
`define FPSS_CPU1_WIN_LSB 0
`define FPSS_CPU2_WIN_LSB 4
`define FPSS_WIN_SEL_W 4
`define FPSS_WIN_SEL_MAX 4'h9
`define FPSS_BIND_ZONE_LSB 0
`define FPSS_BIND_CPU1 4
`define FPSS_BIND_CPU2 5
`define FPSS_BIND_REG1 6
`define FPSS_BIND_REG2 7
`define FPSS_CLK_MHZ 100
`define FPSS_BASE_WIN_MS 730
`define FPSS_BASE_WIN_CYC (`FPSS_BASE_WIN_MS * 1000 * `FPSS_CLK_MHZ)
`define FPSS_WIN_SUBTICKS 256
`define FPSS_RAMP_STEP_MS 10
`define FPSS_RAMP_STEP_CYC (`FPSS_RAMP_STEP_MS * 1000 * `FPSS_CLK_MHZ)
`define FPSS_RAMP_INC 8'h08
`define FPSS_NUM_SRC 8
`endif

/* verilog/fpss_pkg.sv */
// types for fan source select
`default_nettype none
package fpss_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpss_req_t;
  typedef struct packed {
    logic [7:0] zone4;
    logic [7:0] zone3;
    logic [7:0] zone2;
    logic [7:0] zone1;
  } fpss_zones_t;
endpackage : fpss_pkg
`default_nettype wire

/* verilog/fpss_top.sv */
// fan output a source binding and cpu throttle monitoring windows
`timescale 1ns/1ps
`default_nettype none
`include "fpss_cfg.svh"
module fpss_top #(
  parameter int unsigned SUBTICK_CYC = `FPSS_BASE_WIN_CYC / `FPSS_WIN_SUBTICKS,
  parameter int unsigned RAMP_CYC = `FPSS_RAMP_STEP_CYC
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire fpss_pkg::fpss_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire fpss_pkg::fpss_zones_t zones_i,
  input wire logic cpu1_thermal_throttle_i,
  input wire logic cpu2_thermal_throttle_i,
  input wire logic regulator_one_overtemp_i,
  input wire logic regulator_two_overtemp_i,
  output logic [7:0] fan_out_a_duty_o,
  output logic fan_out_a_o,
  output logic [15:0] throttle_measured_value_o,
  output logic [1:0] window_done_o
);
  import fpss_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] interval_q;
  logic [7:0] binding_q;
  logic [7:0] override_q;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      interval_q <= `FPSS_RST_INTERVAL;
      binding_q <= `FPSS_RST_BINDING;
      override_q <= `FPSS_RST_OVERRIDE;
    end else if (req_i.wr) begin
      if (req_i.addr == `FPSS_OFS_INTERVAL) begin
        interval_q <= req_i.wdata;
      end else if (req_i.addr == `FPSS_OFS_BINDING) begin
        binding_q <= req_i.wdata;
      end else if (req_i.addr == `FPSS_OFS_OVERRIDE) begin
        override_q <= req_i.wdata;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (!req_i.rd) begin
        rdata_o <= 8'h00;
      end else if (req_i.addr == `FPSS_OFS_INTERVAL) begin
        rdata_o <= interval_q;
      end else if (req_i.addr == `FPSS_OFS_BINDING) begin
        rdata_o <= binding_q;
      end else if (req_i.addr == `FPSS_OFS_OVERRIDE) begin
        rdata_o <= override_q;
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // enable pulses
  // ----------------------------------------------------------------
  logic [31:0] sub_cnt_q;
  logic sub_tick_q;
  logic [31:0] ramp_cnt_q;
  logic ramp_tick_q;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sub_cnt_q <= 32'h0;
      sub_tick_q <= 1'b0;
    end else if (sub_cnt_q == SUBTICK_CYC - 1) begin
      sub_cnt_q <= 32'h0;
      sub_tick_q <= 1'b1;
    end else begin
      sub_cnt_q <= sub_cnt_q + 32'h1;
      sub_tick_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ramp_cnt_q <= 32'h0;
      ramp_tick_q <= 1'b0;
    end else if (ramp_cnt_q == RAMP_CYC - 1) begin
      ramp_cnt_q <= 32'h0;
      ramp_tick_q <= 1'b1;
    end else begin
      ramp_cnt_q <= ramp_cnt_q + 32'h1;
      ramp_tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // throttle monitoring windows
  // ----------------------------------------------------------------
  logic [1:0] thr_in;
  logic [3:0] win_sel [2];
  assign thr_in = {cpu2_thermal_throttle_i, cpu1_thermal_throttle_i};
  assign win_sel[0] = interval_q[`FPSS_CPU1_WIN_LSB +: `FPSS_WIN_SEL_W];
  assign win_sel[1] = interval_q[`FPSS_CPU2_WIN_LSB +: `FPSS_WIN_SEL_W];

  for (genvar c = 0; c < 2; c++) begin : g_mon
    logic [3:0] sel;
    logic [17:0] win_len;
    logic [17:0] tick_cnt_q;
    logic [17:0] hot_cnt_q;
    logic [17:0] scaled;
    logic [7:0] meas_q;
    logic done_q;
    assign sel = (win_sel[c] > `FPSS_WIN_SEL_MAX) ? `FPSS_WIN_SEL_MAX
                                                   : win_sel[c];
    // window of 256 subticks doubled per code
    assign win_len = 18'(`FPSS_WIN_SUBTICKS) << sel;
    assign scaled = hot_cnt_q >> sel;
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        tick_cnt_q <= 18'h0;
        hot_cnt_q <= 18'h0;
        meas_q <= 8'h00;
        done_q <= 1'b0;
      end else begin
        done_q <= 1'b0;
        if (sub_tick_q) begin
          if (tick_cnt_q >= win_len - 18'h1) begin
            tick_cnt_q <= 18'h0;
            hot_cnt_q <= 18'h0;
            meas_q <= (scaled > 18'hFF) ? 8'hFF
                      : scaled[7:0];
            done_q <= 1'b1;
          end else begin
            tick_cnt_q <= tick_cnt_q + 18'h1;
            hot_cnt_q <= hot_cnt_q + {17'h0, thr_in[c]};
          end
        end
      end
    end
  end
  assign throttle_measured_value_o = {g_mon[1].meas_q, g_mon[0].meas_q};
  assign window_done_o = {g_mon[1].done_q, g_mon[0].done_q};

  // ----------------------------------------------------------------
  // duty requests per source and largest wins
  // ----------------------------------------------------------------
  localparam logic [7:0] LUT [16] = '{
    8'h00, 8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60,
    8'h80, 8'hA0, 8'hC0, 8'hE0, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] zone_t [4];
  logic [3:0] ramp_src;
  logic [7:0] req_duty [`FPSS_NUM_SRC];
  logic [7:0] best [`FPSS_NUM_SRC + 1];
  assign zone_t[0] = zones_i.zone1;
  assign zone_t[1] = zones_i.zone2;
  assign zone_t[2] = zones_i.zone3;
  assign zone_t[3] = zones_i.zone4;
  assign ramp_src = {regulator_two_overtemp_i, regulator_one_overtemp_i,
                     cpu2_thermal_throttle_i, cpu1_thermal_throttle_i};
  assign best[0] = 8'h00;

  for (genvar s = 0; s < `FPSS_NUM_SRC; s++) begin : g_src
    if (s < 4) begin : g_zone
      assign req_duty[s] = LUT[zone_t[s][7:4]];
    end else begin : g_ramp
      logic [7:0] ramp_q;
      always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
          ramp_q <= 8'h00;
        end else if (ramp_tick_q && ramp_src[s-4]) begin
          ramp_q <= (ramp_q > 8'hFF - `FPSS_RAMP_INC) ? 8'hFF
                    : ramp_q + `FPSS_RAMP_INC;
        end else if (ramp_tick_q) begin
          ramp_q <= (ramp_q < `FPSS_RAMP_INC) ? 8'h00
                    : ramp_q - `FPSS_RAMP_INC;
        end
      end
      assign req_duty[s] = ramp_q;
    end
    // bit s binds source s
    assign best[s+1] = (binding_q[s] && req_duty[s] > best[s])
                       ? req_duty[s] : best[s];
  end

  logic [7:0] pwm_cnt_q;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      fan_out_a_duty_o <= 8'h00;
      fan_out_a_o <= 1'b0;
      pwm_cnt_q <= 8'h00;
    end else begin
      fan_out_a_duty_o <= best[`FPSS_NUM_SRC];
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      fan_out_a_o <= (best[`FPSS_NUM_SRC] == 8'hFF) ||
                     (pwm_cnt_q < best[`FPSS_NUM_SRC]);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_rd_interval;
    req_i.rd && req_i.addr == `FPSS_OFS_INTERVAL
      |=> rdata_o == $past(interval_q);
  endproperty
  a_rd_interval: assert property (p_rd_interval)
    else $error("interval read bad");
  property p_rd_binding;
    req_i.rd && req_i.addr == `FPSS_OFS_BINDING
      |=> rdata_o == $past(binding_q);
  endproperty
  a_rd_binding: assert property (p_rd_binding)
    else $error("binding read bad");
  property p_wr_binding;
    req_i.wr && req_i.addr == `FPSS_OFS_BINDING
      |=> binding_q == $past(req_i.wdata);
  endproperty
  a_wr_binding: assert property (p_wr_binding)
    else $error("binding write lost");
  property p_win1_len;
    interval_q[3:0] <= `FPSS_WIN_SEL_MAX
      |-> g_mon[0].win_len == (18'h100 << interval_q[3:0]);
  endproperty
  a_win1_len: assert property (p_win1_len)
    else $error("cpu1 window length bad");
  property p_win2_len;
    interval_q[7:4] <= `FPSS_WIN_SEL_MAX
      |-> g_mon[1].win_len == (18'h100 << interval_q[7:4]);
  endproperty
  a_win2_len: assert property (p_win2_len)
    else $error("cpu2 window length bad");
  property p_none_bound;
    binding_q == 8'h00 |=> fan_out_a_duty_o == 8'h00;
  endproperty
  a_none_bound: assert property (p_none_bound)
    else $error("unbound duty not zero");
  property p_zone_floor;
    binding_q[0] |=> fan_out_a_duty_o >= $past(LUT[zones_i.zone1[7:4]]);
  endproperty
  a_zone_floor: assert property (p_zone_floor)
    else $error("zone duty ignored");
  property p_cpu1_floor;
    binding_q[4] |=> fan_out_a_duty_o >= $past(g_src[4].g_ramp.ramp_q);
  endproperty
  a_cpu1_floor: assert property (p_cpu1_floor)
    else $error("throttle duty ignored");
  property p_reg2_floor;
    binding_q[7] |=> fan_out_a_duty_o >= $past(g_src[7].g_ramp.ramp_q);
  endproperty
  a_reg2_floor: assert property (p_reg2_floor)
    else $error("regulator duty ignored");
  property p_ramp_up;
    ramp_tick_q && ramp_src[0] && g_src[4].g_ramp.ramp_q == 8'h00
      |=> g_src[4].g_ramp.ramp_q == `FPSS_RAMP_INC;
  endproperty
  a_ramp_up: assert property (p_ramp_up)
    else $error("ramp step bad");
  property p_max_only;
    binding_q == 8'h01 ##1 binding_q == 8'h01
      |-> fan_out_a_duty_o == $past(LUT[zones_i.zone1[7:4]]);
  endproperty
  a_max_only: assert property (p_max_only)
    else $error("single source duty bad");
  c_window_done: cover property (@(posedge core_clk_i) window_done_o[0]);
  c_full_duty: cover property (@(posedge core_clk_i) fan_out_a_duty_o == 8'hFF);
  c_rebind: cover property (@(posedge core_clk_i)
    req_i.wr && req_i.addr == `FPSS_OFS_BINDING);
endmodule : fpss_top
`default_nettype wire

/* bench/fpss_partner.sv */
// partner model: cpu throttle and regulator hot drivers, fan load monitor
`timescale 1ns/1ps
`default_nettype none
module fpss_partner (
  input wire logic core_clk_i,
  input wire logic [3:0] hot_i,
  input wire logic clr_i,
  input wire logic fan_out_a_i,
  output logic cpu1_thermal_throttle_o,
  output logic cpu2_thermal_throttle_o,
  output logic regulator_one_overtemp_o,
  output logic regulator_two_overtemp_o,
  output logic [8:0] high_cnt_o
);
  // ------------------------------------------------------------
  // hot signals follow the commanded levels
  // ------------------------------------------------------------
  assign cpu1_thermal_throttle_o = hot_i[0];
  assign cpu2_thermal_throttle_o = hot_i[1];
  assign regulator_one_overtemp_o = hot_i[2];
  assign regulator_two_overtemp_o = hot_i[3];
  // ------------------------------------------------------------
  // fan load counts cycles driven high
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (clr_i) begin
      high_cnt_o <= 9'h000;
    end else if (fan_out_a_i) begin
      high_cnt_o <= high_cnt_o + 9'h001;
    end
  end
endmodule : fpss_partner
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for fan source select
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fpss_pkg::*;
  // ------------------------------------------------------------
  // clock, reset and wiring
  // ------------------------------------------------------------
  localparam int SUB = 2;
  localparam int RAMP = 4;
  localparam logic [7:0] LUT [16] = '{8'h00, 8'h00, 8'h10, 8'h20, 8'h30,
    8'h40, 8'h50, 8'h60, 8'h80, 8'hA0, 8'hC0, 8'hE0, 8'hFF, 8'hFF, 8'hFF,
    8'hFF};
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  fpss_req_t req = '0;
  fpss_zones_t zones = '0;
  logic [3:0] hot = 4'h0;
  logic clr = 1'b0;
  logic [7:0] rdata, duty, v, e;
  logic rvalid, fan, c1, c2, r1, r2;
  logic [15:0] thr;
  logic [1:0] wdone;
  logic [8:0] cnt;
  int failures = 0;
  int comparisons = 0;
  int n;
  int unsigned seed;
  always #5 core_clk_i = ~core_clk_i;
  fpss_top #(.SUBTICK_CYC(SUB), .RAMP_CYC(RAMP)) uut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .zones_i(zones),
    .cpu1_thermal_throttle_i(c1), .cpu2_thermal_throttle_i(c2),
    .regulator_one_overtemp_i(r1), .regulator_two_overtemp_i(r2),
    .fan_out_a_duty_o(duty), .fan_out_a_o(fan),
    .throttle_measured_value_o(thr), .window_done_o(wdone));
  fpss_partner fan_side (.core_clk_i(core_clk_i), .hot_i(hot),
    .clr_i(clr), .fan_out_a_i(fan), .cpu1_thermal_throttle_o(c1),
    .cpu2_thermal_throttle_o(c2), .regulator_one_overtemp_o(r1),
    .regulator_two_overtemp_o(r2), .high_cnt_o(cnt));
  // ------------------------------------------------------------
  // tasks and expectations
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask : wait_cyc
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    req.wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, input logic [7:0] x);
    @(posedge core_clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_i);
    req.rd <= 1'b0;
    #1;
    chk({7'h00, rvalid, rdata}, {8'h01, x});
  endtask : reg_read
  task automatic wait_done(input int b);
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
    end while (wdone[b] !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      failures++;
      $display("Error at %0t: window end timeout", $time);
      finish_test();
    end
  endtask : wait_done
  function automatic logic [7:0] zmax(input logic [3:0] m);
    logic [7:0] r;
    r = 8'h00;
    for (int z = 0; z < 4; z++) begin
      if (m[z] && LUT[zones[8*z+4 +: 4]] > r) r = LUT[zones[8*z+4 +: 4]];
    end
    return r;
  endfunction : zmax
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = $urandom(6);
    wait_cyc(12);
    rstn_i <= 1'b1;
    reg_read(8'hC7, 8'h11);
    reg_read(8'hC8, 8'h0F);
    reg_read(8'hC9, 8'h00);
    reg_write(8'hC6, 8'h5A);
    reg_read(8'hC6, 8'h00);
    repeat (4) begin
      v = {4'($urandom_range(9)), 4'($urandom_range(9))};
      reg_write(8'hC7, v);
      reg_read(8'hC7, v);
      v = 8'($urandom);
      reg_write(8'hC8, v);
      reg_read(8'hC8, v);
      reg_write(8'hC9, ~v);
      reg_read(8'hC9, ~v);
    end
    reg_write(8'hC8, 8'h00);
    wait_cyc(3);
    chk(duty, 8'h00);
    for (int r = 0; r < 5; r++) begin
      @(posedge core_clk_i);
      zones <= (r == 0) ? 32'hFFFF_FFFF : $urandom;
      for (int z = 0; z < 4; z++) begin
        reg_write(8'hC8, 8'h01 << z);
        wait_cyc(3);
        chk(duty, zmax(4'h1 << z));
      end
      reg_write(8'hC8, 8'h0F);
      wait_cyc(3);
      e = zmax(4'hF);
      chk(duty, e);
      clr <= 1'b1;
      @(posedge core_clk_i);
      clr <= 1'b0;
      wait_cyc(256);
      #1;
      chk(cnt, (e == 8'hFF) ? 9'd256 : {1'b0, e});
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk_i);
      hot <= 4'h0;
      wait_cyc(300);
      reg_write(8'hC8, 8'h10 << s);
      hot <= 4'hF ^ (4'h1 << s);
      wait_cyc(300);
      chk(duty, 8'h00);
      hot <= 4'h1 << s;
      wait_cyc(6);
      chk({15'h0, duty != 8'h00 && duty != 8'hFF}, 16'h1);
      wait_cyc(300);
      chk(duty, 8'hFF);
    end
    @(posedge core_clk_i);
    zones <= 32'h0000_0080;
    hot <= 4'h0;
    reg_write(8'hC8, 8'h11);
    wait_cyc(300);
    chk(duty, 8'h80);
    hot <= 4'h1;
    wait_cyc(300);
    chk(duty, 8'hFF);
    reg_write(8'hC7, 8'h10);
    wait_done(0);
    wait_done(0);
    chk(n, SUB * 256);
    chk(thr[7:0], 8'hFF);
    wait_done(1);
    wait_done(1);
    chk(n, SUB * 512);
    chk(thr[15:8], 8'h00);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
